// ===== hdl/rmc_top.sv
// Registered I/O macrocell block with AXI4-Lite configuration
//
// Overview of operation
// - Pin input register clocked by one of two clocks
// - XOR fed by sum-of-products and dedicated term
// - XOR output is output register D input
// - Q into dedicated term makes toggle flip-flop
// - JK via T equals J not-Q or K-Q
// - Dedicated term as constant polarity control
// - Feedback mux returns output or input Q
// - Shared mux gives array a neighbour's input Q
// - Shared mux on six of twelve cells
// - Four buried cells, output logic, no pin
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Output register portion of one macrocell
// ----------------------------------------------------------------------
module rmc_outcell (
	input  wire logic            clock,
	input  wire logic            rst_n,
	input  wire logic            tick,
	input  wire logic            sop,
	input  wire logic            xterm,
	input  wire logic            pol,
	input  wire logic [1:0]      mode,
	output logic                 q
);
	rmc_pkg::rmc_mode_t mode_e;
	logic               xor_a;
	logic               xor_b;
	logic               q_d;

	assign mode_e = rmc_pkg::rmc_mode_t'(mode);

	// Pick the two XOR inputs for the chosen flip-flop flavour
	always_comb begin
		xor_a = sop;
		xor_b = xterm;
		case (mode_e)
			rmc_pkg::MODE_XOR_TERM: xor_b = xterm;
			rmc_pkg::MODE_POLARITY: xor_b = pol;
			rmc_pkg::MODE_TOGGLE:   xor_b = q;
			rmc_pkg::MODE_JK: begin
				// sop is J, dedicated term is K
				xor_a = (sop & ~q) | (xterm & q);
				xor_b = q;
			end
			default: xor_b = xterm;
		endcase
		q_d = xor_a ^ xor_b;
	end

	// Capture only on the rising edge of the output clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else if (tick) begin
			q <= q_d;
		end
	end

endmodule : rmc_outcell

// ----------------------------------------------------------------------
// Top: register file, input registers, muxes, sixteen output cells
// ----------------------------------------------------------------------
module rmc_top (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        dev_clk0,
	input  wire logic        dev_clk1,
	input  wire logic [11:0] pin_in,
	output logic [11:0]      pin_out,
	output logic [11:0]      pin_oe_n,
	input  wire logic [15:0] array_sop,
	input  wire logic [15:0] array_xterm,
	output logic [15:0]      array_fb,
	output logic [5:0]       array_shared
);
	logic [1:0]        rst_sync_q;
	logic              rst_n;
	rmc_pkg::rmc_cfg_t cfg_q;
	logic [11:0]       in_q;
	logic [15:0]       out_q;
	logic              clk0_q;
	logic              clk1_q;
	logic              rise0;
	logic              rise1;
	logic              aw_have_q;
	logic [7:0]        aw_addr_q;
	logic              w_have_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic [31:0]       wmask;
	logic              do_write;
	logic              wr_hit;
	logic [31:0]       rd_word;
	logic              rd_hit;

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------

	// Assert at once, release after two clock edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ------------------------------------------------------------------
	// Device clock edge detection
	// ------------------------------------------------------------------

	// Device clocks are sampled as synchronous levels; a rising edge
	// becomes a one-cycle tick, so they must run below half our rate
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clk0_q <= 1'b0;
			clk1_q <= 1'b0;
		end else begin
			clk0_q <= dev_clk0;
			clk1_q <= dev_clk1;
		end
	end
	assign rise0 = dev_clk0 & ~clk0_q;
	assign rise1 = dev_clk1 & ~clk1_q;

	// ------------------------------------------------------------------
	// Input registers
	// ------------------------------------------------------------------

	// Each pin latches on the edge of its own selected clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_q <= 12'h000;
		end else begin
			for (int i = 0; i < rmc_pkg::NUM_IO; i++) begin
				if (cfg_q.clksel[i] ? rise1 : rise0) begin
					in_q[i] <= pin_in[i];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Output cells, I/O and buried alike
	// ------------------------------------------------------------------
	for (genvar c = 0; c < rmc_pkg::NUM_CELLS; c++) begin : g_cell
		rmc_outcell u_cell (
			.clock (clock),
			.rst_n (rst_n),
			.tick  (rise0),
			.sop   (array_sop[c]),
			.xterm (array_xterm[c]),
			.pol   (cfg_q.pol[c]),
			.mode  (cfg_q.mode[2*c +: 2]),
			.q     (out_q[c])
		);
	end

	// ------------------------------------------------------------------
	// Paths back into the array and out to the pins
	// ------------------------------------------------------------------

	// Feedback mux on I/O cells; buried cells always return their Q
	always_comb begin
		for (int i = 0; i < rmc_pkg::NUM_IO; i++) begin
			array_fb[i] = cfg_q.fbsel[i] ? in_q[i] : out_q[i];
		end
		for (int j = rmc_pkg::NUM_IO; j < rmc_pkg::NUM_CELLS; j++) begin
			array_fb[j] = out_q[j];
		end
	end

	// Only every other I/O cell has a shared mux, picking a neighbour
	always_comb begin
		for (int k = 0; k < rmc_pkg::NUM_SHARED; k++) begin
			array_shared[k] = cfg_q.shsel[k] ? in_q[2*k+1] : in_q[2*k];
		end
	end

	// Buried cells have no pin, so only the low twelve reach pins
	assign pin_out  = out_q[11:0];
	assign pin_oe_n = ~cfg_q.drive;

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------
	assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
	assign do_write      = aw_have_q & w_have_q & ~s_axi_bvalid;

	// Address and data may arrive in either order
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_have_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Byte lanes become a bit mask
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = {8{w_strb_q[b]}};
		end
	end

	always_comb begin
		case (aw_addr_q)
			rmc_pkg::OFS_CLKSEL, rmc_pkg::OFS_FBSEL, rmc_pkg::OFS_SHSEL,
			rmc_pkg::OFS_DRIVE, rmc_pkg::OFS_MODE,
			rmc_pkg::OFS_POL: wr_hit = 1'b1;
			default:          wr_hit = 1'b0;
		endcase
	end

	// Configuration registers steer the whole datapath
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q.clksel <= rmc_pkg::RST_CLKSEL;
			cfg_q.fbsel  <= rmc_pkg::RST_FBSEL;
			cfg_q.shsel  <= rmc_pkg::RST_SHSEL;
			cfg_q.drive  <= rmc_pkg::RST_DRIVE;
			cfg_q.mode   <= rmc_pkg::RST_MODE;
			cfg_q.pol    <= rmc_pkg::RST_POL;
		end else if (do_write) begin
			case (aw_addr_q)
				rmc_pkg::OFS_CLKSEL: cfg_q.clksel <= (cfg_q.clksel &
					~wmask[11:0]) | (w_data_q[11:0] & wmask[11:0]);
				rmc_pkg::OFS_FBSEL: cfg_q.fbsel <= (cfg_q.fbsel &
					~wmask[11:0]) | (w_data_q[11:0] & wmask[11:0]);
				rmc_pkg::OFS_SHSEL: cfg_q.shsel <= (cfg_q.shsel &
					~wmask[5:0]) | (w_data_q[5:0] & wmask[5:0]);
				rmc_pkg::OFS_DRIVE: cfg_q.drive <= (cfg_q.drive &
					~wmask[11:0]) | (w_data_q[11:0] & wmask[11:0]);
				rmc_pkg::OFS_MODE: cfg_q.mode <= (cfg_q.mode &
					~wmask) | (w_data_q & wmask);
				rmc_pkg::OFS_POL: cfg_q.pol <= (cfg_q.pol &
					~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
				default: ;
			endcase
		end
	end

	// Response one cycle after both halves are held
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= rmc_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? rmc_pkg::RESP_OKAY
						: rmc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	// Read decode; state word shows live register contents
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			rmc_pkg::OFS_CLKSEL: rd_word[11:0] = cfg_q.clksel;
			rmc_pkg::OFS_FBSEL:  rd_word[11:0] = cfg_q.fbsel;
			rmc_pkg::OFS_SHSEL:  rd_word[5:0]  = cfg_q.shsel;
			rmc_pkg::OFS_DRIVE:  rd_word[11:0] = cfg_q.drive;
			rmc_pkg::OFS_MODE:   rd_word       = cfg_q.mode;
			rmc_pkg::OFS_POL:    rd_word[15:0] = cfg_q.pol;
			rmc_pkg::OFS_STATE: begin
				rd_word[rmc_pkg::STATE_OUT_LSB +: 16] = out_q;
				rd_word[rmc_pkg::STATE_IN_LSB +: 12]  = in_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= rmc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? rmc_pkg::RESP_OKAY
						: rmc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : rmc_top

// ===== hdl/rmc_pkg.sv
// Shared constants and types for the registered I/O macrocell block
package rmc_pkg;

	// ------------------------------------------------------------------
	// Cell counts
	// ------------------------------------------------------------------
	localparam int unsigned NUM_IO     = 12;
	localparam int unsigned NUM_BURIED = 4;
	localparam int unsigned NUM_CELLS  = NUM_IO + NUM_BURIED;
	localparam int unsigned NUM_SHARED = NUM_IO / 2;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CLKSEL = 8'h00;
	localparam logic [7:0] OFS_FBSEL  = 8'h04;
	localparam logic [7:0] OFS_SHSEL  = 8'h08;
	localparam logic [7:0] OFS_DRIVE  = 8'h0c;
	localparam logic [7:0] OFS_MODE   = 8'h10;
	localparam logic [7:0] OFS_POL    = 8'h14;
	localparam logic [7:0] OFS_STATE  = 8'h18;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned STATE_OUT_LSB = 0;
	localparam int unsigned STATE_IN_LSB  = 16;
	localparam logic [11:0] RST_CLKSEL    = 12'h000;
	localparam logic [11:0] RST_FBSEL     = 12'h000;
	localparam logic [5:0]  RST_SHSEL     = 6'h00;
	localparam logic [11:0] RST_DRIVE     = 12'h000;
	localparam logic [31:0] RST_MODE      = 32'h0000_0000;
	localparam logic [15:0] RST_POL       = 16'h0000;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Output register D-input modes
	typedef enum logic [1:0] {
		MODE_XOR_TERM,
		MODE_POLARITY,
		MODE_TOGGLE,
		MODE_JK
	} rmc_mode_t;

	// Configuration carried from the register file to the cells
	typedef struct packed {
		logic [11:0] clksel;
		logic [11:0] fbsel;
		logic [5:0]  shsel;
		logic [11:0] drive;
		logic [31:0] mode;
		logic [15:0] pol;
	} rmc_cfg_t;

endpackage : rmc_pkg

// ===== verification/rmc_pins.sv
// Pin partner model: resolves each two-way pin for the block
`timescale 1ns/1ps
module rmc_pins (
	input  wire logic [11:0] ext,
	input  wire logic [11:0] drv,
	input  wire logic [11:0] oe_n,
	output logic      [11:0] pin
);
	// A driven pin reads back its own level, a free one the outside
	assign pin = (drv & ~oe_n) | (ext & oe_n);
endmodule : rmc_pins

// ===== verification/rmc_checker.sv
// Bus and capture timing assertions for the macrocell block
`timescale 1ns/1ps
module rmc_checker (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        dev_clk0,
	input wire logic [11:0] pin_out,
	input wire logic [15:0] array_fb
);
	// ----------------------------------------------------------
	// One domain, so clock and reset are given once
	// ----------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read not refused");
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write answer moved");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:3] s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_wr_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("write not refused");
	// Output registers move only after a device clock rise
	property p_out_hold;
		!(dev_clk0 && !$past(dev_clk0)) |=> $stable(pin_out);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("pin moved");
	property p_fb_hold;
		!(dev_clk0 && !$past(dev_clk0)) |=> $stable(array_fb[15:12]);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("buried moved");
endmodule : rmc_checker

bind rmc_top rmc_checker u_checker (.*);

// ===== verification/tb_registered_io_macrocell.sv
// Self-checking bench for the registered I/O macrocell block
`timescale 1ns/1ps
module tb_registered_io_macrocell;
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic dev_clk0 = 1'h0, dev_clk1 = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [15:0] array_sop = 16'h0, array_xterm = 16'h0;
	logic [11:0] ext = 12'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [11:0] pin_in, pin_out, pin_oe_n;
	logic [15:0] array_fb;
	logic [5:0] array_shared;
	// Shadow of the configuration and the expected flop contents
	logic [15:0] in_e = 16'h0, out_e = 16'h0, csel = 16'h0, drv = 16'h0;
	logic [15:0] pol = 16'h0;
	logic [1:0] mode = 2'h0;
	int failures = 0, comparisons = 0;

	always #4 clock = ~clock;
	rmc_top dut (.*);
	rmc_pins u_pins (.ext(ext), .drv(pin_out), .oe_n(pin_oe_n), .pin(pin_in));

	// ----------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------
	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Answer handshakes are accepted one cycle late to stall the slave
	task automatic wr(logic [7:0] a, logic [31:0] d,
		logic [1:0] r = rmc_pkg::RESP_OKAY);
		logic got = 1'h0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				got = 1'h1;
				s_axi_bready <= 1'h0;
				chk("bresp", r, s_axi_bresp);
			end else if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end
		if (!got) begin
			failures++;
			summarize();
		end
	endtask : wr

	task automatic rd(logic [7:0] a, logic [31:0] e,
		logic [1:0] r = rmc_pkg::RESP_OKAY);
		logic got = 1'h0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				got = 1'h1;
				s_axi_rready <= 1'h0;
				chk("rdata", e, s_axi_rdata);
				chk("rresp", r, s_axi_rresp);
			end else if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end
		if (!got) begin
			failures++;
			summarize();
		end
	endtask : rd

	task automatic st();
		rd(rmc_pkg::OFS_STATE, {4'h0, in_e[11:0], out_e});
	endtask : st

	function automatic logic nx(logic q, logic s, logic x, logic p);
		case (mode)
			2'h0: return s ^ x;
			2'h1: return s ^ p;
			2'h2: return s ^ q;
			default: return q ^ ((s & ~q) | (x & q));
		endcase
	endfunction : nx

	// Pins are sampled before the output flops move at the same edge
	task automatic tick(logic k);
		repeat (2) @(posedge clock);
		for (int i = 0; i < 16; i++) begin
			if (i < 12 && csel[i] == k) in_e[i] = drv[i] ? out_e[i] : ext[i];
			if (!k) out_e[i] = nx(out_e[i], array_sop[i], array_xterm[i], pol[i]);
		end
		if (k) dev_clk1 <= 1'h1;
		else dev_clk0 <= 1'h1;
		repeat (2) @(posedge clock);
		dev_clk0 <= 1'h0;
		dev_clk1 <= 1'h0;
		repeat (3) @(posedge clock);
	endtask : tick

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'h1;
		repeat (3) @(posedge clock);
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
		rd(8'h1c, 32'h0, rmc_pkg::RESP_SLVERR);
		wr(rmc_pkg::OFS_STATE, 32'hffff_ffff, rmc_pkg::RESP_SLVERR);
		st();
		s_axi_wstrb <= 4'h1;
		wr(rmc_pkg::OFS_POL, 32'hffff_ffff);
		s_axi_wstrb <= 4'hf;
		pol = 16'h00ff;
		rd(rmc_pkg::OFS_POL, 32'h0000_00ff);
		// Cell 0 follows the second device clock only
		wr(rmc_pkg::OFS_CLKSEL, 32'h1);
		csel = 16'h0001;
		ext <= 12'h999;
		tick(1'h0);
		st();
		tick(1'h1);
		st();
		// Every mode against every term pair, buried cells included
		for (int m = 0; m < 4; m++) begin
			mode = 2'(m);
			wr(rmc_pkg::OFS_MODE, {16{mode}});
			for (int v = 0; v < 4; v++) begin
				array_sop <= 16'h3c5a ^ {16{v[0]}};
				array_xterm <= 16'h6699 ^ {16{v[1]}};
				tick(1'h0);
				st();
				chk("pin_out", out_e[11:0], pin_out);
			end
		end
		chk("fb", out_e, array_fb);
		chk("shared", 6'h15, array_shared);
		wr(rmc_pkg::OFS_FBSEL, 32'hfff);
		chk("fb", {out_e[15:12], in_e[11:0]}, array_fb);
		wr(rmc_pkg::OFS_SHSEL, 32'h2a);
		chk("shared", 6'h3f, array_shared);
		// Driven pins feed their own output back into the input flops
		wr(rmc_pkg::OFS_DRIVE, 32'hf0f);
		drv = 16'h0f0f;
		chk("oe_n", 12'h0f0, pin_oe_n);
		array_sop <= 16'hffff;
		ext <= 12'h000;
		tick(1'h1);
		tick(1'h0);
		st();
		summarize();
	end
endmodule : tb_registered_io_macrocell
